// file: design/hapi_defines.svh
`ifndef HAPI_DEFINES_SVH
`define HAPI_DEFINES_SVH

// ---------------------------------------------------------------
// bus addressing
// ---------------------------------------------------------------
`define HAPI_DEV_ADDR 7'h5A
`define HAPI_ADDR_WR 8'hB4
`define HAPI_ADDR_RD 8'hB5

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define HAPI_REG_FAULT 8'h01
`define HAPI_REG_LOAD 8'h02
`define HAPI_REG_CTRL 8'h03
`define HAPI_CTRL_RST 8'h00
`define HAPI_CTRL_MASK 8'hF9
`define HAPI_GAIN_MSB 7
`define HAPI_GAIN_LSB 6
`define HAPI_PEAK_MSB 5
`define HAPI_PEAK_LSB 3
`define HAPI_RATE_BIT 0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define HAPI_CLK_PERIOD_NS 10
`define HAPI_SCL_PERIOD_NS 10000
`define HAPI_QTR_CYC ((`HAPI_SCL_PERIOD_NS / 4) / `HAPI_CLK_PERIOD_NS)

`endif

// file: design/hapi_pkg.sv
package hapi_pkg;
    typedef logic [7:0] hapi_byte_t;
    typedef logic [1:0] hapi_gain_t;
    typedef logic [2:0] hapi_peak_t;

    typedef enum logic [8:0] {
        DS_IDLE = 9'h001,
        DS_ADDR = 9'h002,
        DS_AACK = 9'h004,
        DS_PTR = 9'h008,
        DS_PACK = 9'h010,
        DS_WDAT = 9'h020,
        DS_WACK = 9'h040,
        DS_RDAT = 9'h080,
        DS_RACK = 9'h100
    } hapi_dev_state_t;

    typedef enum logic [8:0] {
        HS_IDLE = 9'h001,
        HS_START = 9'h002,
        HS_ADDRW = 9'h004,
        HS_PTR = 9'h008,
        HS_WDAT = 9'h010,
        HS_RSTART = 9'h020,
        HS_ADDRR = 9'h040,
        HS_RDAT = 9'h080,
        HS_STOP = 9'h100
    } hapi_host_state_t;
endpackage : hapi_pkg

// file: design/hapi_link_if.sv
`timescale 1ns/1ps
interface hapi_link_if;
    logic scl_host_o;
    logic scl_host_oe;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic scl;
    logic sda;

    // wired-and with pull-ups: a released line reads high
    assign scl = scl_host_oe ? scl_host_o : 1'b1;
    assign sda = (sda_host_oe ? sda_host_o : 1'b1)
               & (sda_dev_oe ? sda_dev_o : 1'b1);

    modport host (
        output scl_host_o, scl_host_oe, sda_host_o, sda_host_oe,
        input scl, sda
    );
    modport dev (
        output sda_dev_o, sda_dev_oe,
        input scl, sda
    );
endinterface : hapi_link_if

// file: design/hapi_dev.sv
`timescale 1ns/1ps
`include "hapi_defines.svh"
// Behaviour
// RULE1 - bytes are eight bits, MSB first
// RULE2 - receiver acknowledges each byte next clock
// RULE3 - master frames transfers with start, stop
// RULE4 - data changes only while clock low
// RULE5 - answer only to address 0x5A
// RULE6 - acknowledge holds data low whole period
// RULE7 - unlimited bytes; master ends with stop
// RULE8 - write: address then pointer, both acknowledged
// RULE9 - write data fills pointer, then next registers
// RULE10 - every written data byte is acknowledged
// RULE11 - read: pointer write, repeated start, address
// RULE12 - read returns registers while master acknowledges
// RULE13 - master acknowledges all but last byte
// RULE14 - any register allows single or burst access
// RULE15 - fault bit 7 is over-temperature, resets zero
// RULE16 - fault bit 6 is offset trip
// RULE17 - fault bits 5,4 are supply high, low
// RULE18 - fault bits 3,2 are current, load fault
// RULE19 - fault bits 1:0 reserved, read zero
// RULE20 - status register holds mode and load flags
// RULE21 - control: gain, peak limit, switching rate
// RULE22 - reset returns every register to default
// RULE23 - foreign address: stay released, ignore transfer
// RULE24 - writes to status registers acknowledged, dropped
module hapi_dev (
    // system clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // link clock and bus pins
    input wire logic link_clk,
    hapi_link_if.dev link,
    // protection flags
    input wire logic over_temp_flag,
    input wire logic output_offset_trip_flag,
    input wire logic supply_high_flag,
    input wire logic supply_low_flag,
    input wire logic current_trip_flag,
    input wire logic load_fault_seen_flag,
    // device and load state
    input wire logic powered_up_flag,
    input wire logic low_power_wait_flag,
    input wire logic diag_running_flag,
    input wire logic any_fault_flag,
    input wire logic load_short_flag,
    input wire logic load_open_flag,
    input wire logic short_gnd_flag,
    input wire logic short_supply_flag,
    // control settings
    output hapi_pkg::hapi_gain_t gain_sel,
    output hapi_pkg::hapi_peak_t peak_limit_sel,
    output logic switching_rate_select
);
    import hapi_pkg::*;

    // ---------------------------------------------------------------
    // link-domain reset and pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0] lrst_r;
    logic lrst_n;
    logic [2:0] scl_r;
    logic [2:0] sda_r;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    always_ff @(posedge link_clk) begin
        lrst_r <= {lrst_r[0], rst_n};
    end
    assign lrst_n = lrst_r[1];

    // [0] first stage, [1] synced level, [2] previous synced level
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            scl_r <= 3'h7;
            sda_r <= 3'h7;
        end else begin
            scl_r <= {scl_r[1:0], link.scl};
            sda_r <= {sda_r[1:0], link.sda};
        end
    end

    assign scl_rise = scl_r[1] & ~scl_r[2];
    assign scl_fall = ~scl_r[1] & scl_r[2];
    assign start_det = scl_r[1] & scl_r[2] & sda_r[2] & ~sda_r[1]; // [RULE3]
    assign stop_det = scl_r[1] & scl_r[2] & ~sda_r[2] & sda_r[1]; // [RULE3]

    // ---------------------------------------------------------------
    // status flags into the link domain
    // ---------------------------------------------------------------
    logic [13:0] stat_in;
    logic [13:0] stat_s;

    assign stat_in = {over_temp_flag, output_offset_trip_flag,
                      supply_high_flag, supply_low_flag,
                      current_trip_flag, load_fault_seen_flag,
                      powered_up_flag, low_power_wait_flag,
                      diag_running_flag, any_fault_flag,
                      load_short_flag, load_open_flag,
                      short_gnd_flag, short_supply_flag};

    for (genvar i = 0; i < 14; i++) begin : g_stat_sync
        logic meta_r;
        logic sync_r;
        always_ff @(posedge link_clk) begin
            if (!lrst_n) begin
                meta_r <= 1'b0;
                sync_r <= 1'b0;
            end else begin
                meta_r <= stat_in[i];
                sync_r <= meta_r;
            end
        end
        assign stat_s[i] = sync_r;
    end

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    hapi_dev_state_t state_r;
    logic [3:0] bit_cnt_r;
    hapi_byte_t shift_r;
    hapi_byte_t ptr_r;
    hapi_byte_t ctrl_r;
    hapi_byte_t rd_now;
    logic ctrl_tog_r;
    logic rw_r;
    logic mack_r;
    logic sda_oe_r;
    logic byte_done;
    logic addr_hit;
    logic wr_stb;
    logic rd_adv;

    always_comb begin
        case (ptr_r) // [RULE14]
            `HAPI_REG_FAULT: begin // [RULE15] [RULE16] [RULE17] [RULE18]
                rd_now = {stat_s[13:8], 2'h0}; // [RULE19]
            end
            `HAPI_REG_LOAD: rd_now = stat_s[7:0]; // [RULE20]
            `HAPI_REG_CTRL: rd_now = ctrl_r;
            default: rd_now = 8'h00;
        endcase
    end

    assign byte_done = scl_fall & (bit_cnt_r == 4'h8);
    assign addr_hit = shift_r[7:1] == `HAPI_DEV_ADDR; // [RULE5]
    assign wr_stb = (state_r == DS_WDAT) & byte_done;
    assign rd_adv = (state_r == DS_RDAT) & scl_fall & (bit_cnt_r == 4'h7);

    // status registers take no write; the data is still acknowledged
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            ctrl_r <= `HAPI_CTRL_RST; // [RULE22]
            ctrl_tog_r <= 1'b0;
        end else if (wr_stb && ptr_r == `HAPI_REG_CTRL) begin // [RULE24]
            ctrl_r <= shift_r & `HAPI_CTRL_MASK; // [RULE21]
            ctrl_tog_r <= ~ctrl_tog_r;
        end
    end

    // pointer wraps at 8 bits so bursts never stop on their own
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            ptr_r <= 8'h00;
        end else if (state_r == DS_PTR && byte_done) begin
            ptr_r <= shift_r; // [RULE8]
        end else if (wr_stb || rd_adv) begin
            ptr_r <= ptr_r + 8'h01; // [RULE9] [RULE12] [RULE24] [RULE7]
        end
    end

    // ---------------------------------------------------------------
    // byte engine
    // ---------------------------------------------------------------
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            state_r <= DS_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            rw_r <= 1'b0;
            mack_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (stop_det) begin
            state_r <= DS_IDLE;
            sda_oe_r <= 1'b0;
        end else if (start_det) begin
            state_r <= DS_ADDR;
            bit_cnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
        end else begin
            unique case (state_r)
                DS_IDLE: begin
                end
                DS_ADDR, DS_PTR, DS_WDAT: begin
                    if (scl_rise && bit_cnt_r != 4'h8) begin
                        shift_r <= {shift_r[6:0], sda_r[1]}; // [RULE1]
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (byte_done) begin
                        if (state_r == DS_PTR) begin
                            sda_oe_r <= 1'b1; // [RULE8]
                            state_r <= DS_PACK;
                        end else if (state_r == DS_WDAT) begin
                            sda_oe_r <= 1'b1; // [RULE10]
                            state_r <= DS_WACK;
                        end else if (addr_hit) begin
                            sda_oe_r <= 1'b1; // [RULE2] [RULE6]
                            rw_r <= shift_r[0];
                            state_r <= DS_AACK;
                        end else begin
                            state_r <= DS_IDLE; // [RULE23]
                        end
                    end
                end
                DS_AACK, DS_PACK, DS_WACK: begin
                    // ack stays low until the clock falls again
                    if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        if (state_r == DS_AACK && rw_r) begin
                            state_r <= DS_RDAT;
                            shift_r <= rd_now;
                            sda_oe_r <= ~rd_now[7]; // [RULE4]
                        end else begin
                            sda_oe_r <= 1'b0;
                            state_r <= (state_r == DS_AACK) ? DS_PTR
                                                            : DS_WDAT;
                        end
                    end
                end
                DS_RDAT: begin
                    if (scl_fall) begin
                        if (bit_cnt_r == 4'h7) begin
                            sda_oe_r <= 1'b0;
                            state_r <= DS_RACK;
                        end else begin
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                            shift_r <= {shift_r[6:0], 1'b0};
                            sda_oe_r <= ~shift_r[6]; // [RULE1] [RULE4]
                        end
                    end
                end
                DS_RACK: begin
                    if (scl_rise) begin
                        mack_r <= ~sda_r[1];
                    end else if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        if (mack_r) begin
                            state_r <= DS_RDAT; // [RULE12]
                            shift_r <= rd_now;
                            sda_oe_r <= ~rd_now[7];
                        end else begin
                            state_r <= DS_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign link.sda_dev_o = 1'b0;
    assign link.sda_dev_oe = sda_oe_r;

    // ---------------------------------------------------------------
    // control copy into the system domain
    // ---------------------------------------------------------------
    // ctrl_r is held for at least a whole byte after each toggle,
    // far longer than the three-flop toggle path needs
    logic [2:0] tog_r;
    hapi_byte_t ctrl_sys_r;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tog_r <= 3'h0;
        end else begin
            tog_r <= {tog_r[1:0], ctrl_tog_r};
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_sys_r <= `HAPI_CTRL_RST; // [RULE22]
        end else if (tog_r[2] ^ tog_r[1]) begin
            ctrl_sys_r <= ctrl_r; // [RULE21]
        end
    end

    assign gain_sel = ctrl_sys_r[`HAPI_GAIN_MSB:`HAPI_GAIN_LSB];
    assign peak_limit_sel = ctrl_sys_r[`HAPI_PEAK_MSB:`HAPI_PEAK_LSB];
    assign switching_rate_select = ctrl_sys_r[`HAPI_RATE_BIT];
endmodule : hapi_dev

// file: design/hapi_host.sv
`timescale 1ns/1ps
`include "hapi_defines.svh"
module hapi_host (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // bus pins
    hapi_link_if.host link,
    // request
    input wire logic req_valid,
    input wire logic req_read,
    input wire hapi_pkg::hapi_byte_t req_ptr,
    input wire hapi_pkg::hapi_byte_t req_count,
    input wire hapi_pkg::hapi_byte_t wr_data,
    // answer
    output logic busy,
    output logic wr_take,
    output hapi_pkg::hapi_byte_t rd_data,
    output logic rd_valid,
    output logic done,
    output logic nack_seen
);
    import hapi_pkg::*;

    localparam logic [11:0] QTR_LAST = 12'(`HAPI_QTR_CYC - 1);

    // ---------------------------------------------------------------
    // quarter-period timing of the generated clock
    // ---------------------------------------------------------------
    hapi_host_state_t state_r;
    logic [11:0] q_cnt_r;
    logic [1:0] ph_r;
    logic tick;
    logic [1:0] sda_r;

    assign tick = q_cnt_r == QTR_LAST;

    always_ff @(posedge clock) begin
        if (!rst_n || state_r == HS_IDLE || tick) begin
            q_cnt_r <= 12'h000;
        end else begin
            q_cnt_r <= q_cnt_r + 12'h001;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n || state_r == HS_IDLE) begin
            ph_r <= 2'h0;
        end else if (tick) begin
            ph_r <= ph_r + 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sda_r <= 2'h3;
        end else begin
            sda_r <= {sda_r[0], link.sda};
        end
    end

    // ---------------------------------------------------------------
    // transfer sequencer
    // ---------------------------------------------------------------
    logic [3:0] bit_cnt_r;
    hapi_byte_t shift_r;
    hapi_byte_t ptr_r;
    hapi_byte_t remain_r;
    logic rw_r;
    logic ack_r;
    logic scl_oe_r;
    logic sda_oe_r;
    logic last_bit;
    logic tx_low;

    assign last_bit = bit_cnt_r == 4'h8;

    always_comb begin
        if (state_r == HS_RDAT) begin
            tx_low = last_bit && remain_r > 8'h01; // [RULE13]
        end else begin
            tx_low = !last_bit && !shift_r[7]; // [RULE1]
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= HS_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            ptr_r <= 8'h00;
            remain_r <= 8'h00;
            rw_r <= 1'b0;
            ack_r <= 1'b0;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            busy <= 1'b0;
            wr_take <= 1'b0;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
            done <= 1'b0;
            nack_seen <= 1'b0;
        end else begin
            wr_take <= 1'b0;
            rd_valid <= 1'b0;
            done <= 1'b0;
            if (state_r == HS_IDLE) begin
                if (req_valid) begin
                    state_r <= HS_START;
                    rw_r <= req_read;
                    ptr_r <= req_ptr;
                    remain_r <= req_count;
                    busy <= 1'b1;
                    nack_seen <= 1'b0;
                end
            end else if (tick) begin
                unique case (state_r)
                    HS_IDLE: begin
                    end
                    HS_START, HS_RSTART: begin
                        unique case (ph_r)
                            2'h0: sda_oe_r <= 1'b0;
                            2'h1: scl_oe_r <= 1'b0;
                            2'h2: sda_oe_r <= 1'b1; // [RULE3]
                            2'h3: begin
                                scl_oe_r <= 1'b1;
                                bit_cnt_r <= 4'h0;
                                if (state_r == HS_START) begin
                                    state_r <= HS_ADDRW; // [RULE8]
                                    shift_r <= `HAPI_ADDR_WR;
                                end else begin
                                    state_r <= HS_ADDRR; // [RULE11]
                                    shift_r <= `HAPI_ADDR_RD;
                                end
                            end
                        endcase
                    end
                    HS_STOP: begin
                        unique case (ph_r)
                            2'h0: sda_oe_r <= 1'b1;
                            2'h1: scl_oe_r <= 1'b0;
                            2'h2: sda_oe_r <= 1'b0; // [RULE3] [RULE7]
                            2'h3: begin
                                state_r <= HS_IDLE;
                                busy <= 1'b0;
                                done <= 1'b1;
                            end
                        endcase
                    end
                    HS_ADDRW, HS_PTR, HS_WDAT, HS_ADDRR, HS_RDAT: begin
                        unique case (ph_r)
                            2'h0: sda_oe_r <= tx_low; // [RULE4] [RULE2]
                            2'h1: scl_oe_r <= 1'b0;
                            2'h2: begin
                                if (last_bit) begin
                                    ack_r <= ~sda_r[1];
                                end else begin
                                    shift_r <= {shift_r[6:0], sda_r[1]};
                                end
                            end
                            2'h3: begin
                                scl_oe_r <= 1'b1;
                                bit_cnt_r <= last_bit ? 4'h0
                                                      : bit_cnt_r + 4'h1;
                                if (last_bit) begin
                                    // a refused byte ends the transfer
                                    if (state_r == HS_RDAT) begin
                                        rd_data <= shift_r;
                                        rd_valid <= 1'b1;
                                        if (remain_r > 8'h01) begin
                                            remain_r <= remain_r - 8'h01;
                                        end else begin
                                            state_r <= HS_STOP; // [RULE13]
                                        end
                                    end else if (!ack_r) begin
                                        nack_seen <= 1'b1;
                                        state_r <= HS_STOP;
                                    end else if (state_r == HS_ADDRW) begin
                                        state_r <= HS_PTR;
                                        shift_r <= ptr_r;
                                    end else if (state_r == HS_ADDRR) begin
                                        state_r <= HS_RDAT;
                                    end else if (state_r == HS_PTR
                                                 && rw_r) begin
                                        state_r <= HS_RSTART; // [RULE11]
                                    end else if (state_r == HS_PTR
                                                 && remain_r != 8'h00) begin
                                        state_r <= HS_WDAT;
                                        shift_r <= wr_data;
                                        wr_take <= 1'b1;
                                    end else if (state_r == HS_WDAT
                                                 && remain_r > 8'h01) begin
                                        remain_r <= remain_r - 8'h01;
                                        shift_r <= wr_data;
                                        wr_take <= 1'b1;
                                    end else begin
                                        state_r <= HS_STOP; // [RULE7]
                                    end
                                end
                            end
                        endcase
                    end
                endcase
            end
        end
    end

    assign link.scl_host_o = 1'b0;
    assign link.scl_host_oe = scl_oe_r;
    assign link.sda_host_o = 1'b0;
    assign link.sda_host_oe = sda_oe_r;
endmodule : hapi_host

// file: sim/hapi_link_checker.sv
`timescale 1ns/1ps
module hapi_link_checker (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // resolved bus and drivers
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_host_oe,
    input wire logic sda_dev_oe
);
    // ----------------------------------------
    // link rules, sampled on the system clock
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_od; sda_dev_oe |-> !sda; endproperty
    a_od: assert property (p_od)
        else $error("device drive did not pull data low");
    property p_hold; scl && $past(scl) |-> $stable(sda_dev_oe); endproperty
    a_hold: assert property (p_hold)
        else $error("device changed data while clock high");
    property p_ack; $rose(scl) && sda_dev_oe |=> sda_dev_oe [*8]; endproperty
    a_ack: assert property (p_ack)
        else $error("device dropped data low in clock high");
    property p_next; $rose(sda_dev_oe) |-> ##[1:600] $rose(scl); endproperty
    a_next: assert property (p_next)
        else $error("no clock pulse for device bit");
    property p_stop; scl && $rose(sda) |-> !sda_dev_oe; endproperty
    a_stop: assert property (p_stop)
        else $error("device held data at stop");
    property p_start; scl && $fell(sda) |-> !sda_dev_oe; endproperty
    a_start: assert property (p_start)
        else $error("device drove data at start");
    property p_host;
        scl && $past(scl) && $changed(sda_host_oe) |-> !sda_dev_oe;
    endproperty
    a_host: assert property (p_host)
        else $error("host data edge in clock high clashed");
    property p_rel; $fell(sda_dev_oe) |-> !scl [*2]; endproperty
    a_rel: assert property (p_rel)
        else $error("device released data outside clock low");
endmodule : hapi_link_checker

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import hapi_pkg::*;
    logic clock, link_clk, rst_n, req_valid, req_read, ack9;
    logic busy, wr_take, rd_valid, done, nack_seen, switching_rate_select;
    hapi_byte_t req_ptr, req_count, wr_data, rd_data, first, ctl;
    hapi_byte_t rdq[$];
    hapi_gain_t gain_sel;
    hapi_peak_t peak_limit_sel;
    logic [5:0] flt;
    logic [7:0] st;
    int error_cnt, checked, bitn;
    hapi_link_if i_hapi_link_if();
    hapi_dev i_hapi_dev(.clock, .rst_n, .link_clk, .link(i_hapi_link_if),
        .over_temp_flag(flt[5]), .output_offset_trip_flag(flt[4]),
        .supply_high_flag(flt[3]), .supply_low_flag(flt[2]),
        .current_trip_flag(flt[1]), .load_fault_seen_flag(flt[0]),
        .powered_up_flag(st[7]), .low_power_wait_flag(st[6]),
        .diag_running_flag(st[5]), .any_fault_flag(st[4]),
        .load_short_flag(st[3]), .load_open_flag(st[2]),
        .short_gnd_flag(st[1]), .short_supply_flag(st[0]),
        .gain_sel, .peak_limit_sel, .switching_rate_select);
    hapi_host i_hapi_host(.clock, .rst_n, .link(i_hapi_link_if),
        .req_valid, .req_read, .req_ptr, .req_count, .wr_data, .busy,
        .wr_take, .rd_data, .rd_valid, .done, .nack_seen);
    hapi_link_checker i_hapi_link_checker(.clock, .rst_n,
        .scl(i_hapi_link_if.scl), .sda(i_hapi_link_if.sda),
        .sda_host_oe(i_hapi_link_if.sda_host_oe),
        .sda_dev_oe(i_hapi_link_if.sda_dev_oe));
    assign ctl = {gain_sel, peak_limit_sel, 2'b00, switching_rate_select};
    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    // odd offset keeps the link clock out of step with the system clock
    initial begin
        link_clk = 0;
        #1.7;
        forever #3 link_clk = ~link_clk;
    end
    // ----------------------------------------
    // wire monitor: first byte after each start
    // ----------------------------------------
    always @(negedge i_hapi_link_if.sda) if (i_hapi_link_if.scl) bitn = 0;
    always @(posedge i_hapi_link_if.scl) begin
        if (bitn < 8) first = {first[6:0], i_hapi_link_if.sda};
        if (bitn == 8) ack9 = i_hapi_link_if.sda;
        bitn++;
    end
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic xfer(logic rd, hapi_byte_t ptr, hapi_byte_t cnt);
        int n;
        {req_read, req_ptr, req_count, req_valid} = {rd, ptr, cnt, 1'b1};
        @(posedge clock);
        #1 req_valid = 0;
        chk("busy", {7'h00, busy}, 8'h01);
        n = 0;
        // a transfer is some 200 quarters of 250 clocks
        while (done !== 1'b1 && n < 60000) begin
            @(posedge clock);
            #1 n++;
            if (wr_take === 1'b1) wr_data = 8'hC9;
            if (rd_valid === 1'b1) rdq.push_back(rd_data);
        end
        chk("done", {7'h00, done}, 8'h01);
        chk("idle", {7'h00, busy}, 8'h00);
    endtask : xfer
    task automatic t_write;
        chk("ctrl reset", ctl, 8'h00);
        wr_data = 8'hFF;
        xfer(1'b0, 8'h02, 8'h02);
        chk("addr byte", first, 8'hB4);
        chk("addr ack", {7'h00, ack9}, 8'h00);
        chk("nack", {7'h00, nack_seen}, 8'h00);
        chk("ctrl", ctl, 8'hC9);
        $display("test write ended");
    endtask : t_write
    task automatic t_read;
        xfer(1'b1, 8'h01, 8'h02);
        chk("addr byte", first, 8'hB5);
        chk("count", 8'(rdq.size()), 8'h02);
        chk("fault hi", rdq[0] & 8'hF0, 8'hA0);
        chk("fault lo", rdq[0] & 8'h0F, 8'h08);
        chk("state", rdq[1], 8'hB5);
        $display("test read ended");
    endtask : t_read
    // control was written earlier, so a reset must bring it back
    task automatic t_reset;
        rst_n = 0;
        repeat (20) @(posedge clock);
        #1 rst_n = 1;
        repeat (3) @(posedge clock);
        #1;
        chk("ctrl after reset", ctl, 8'h00);
        chk("busy after reset", {7'h00, busy}, 8'h00);
        $display("test reset ended");
    endtask : t_reset
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out
    initial begin
        // write and read take some 86000 clocks together
        #950000;
        error_cnt++;
        close_out();
    end
    initial begin
        {rst_n, req_valid, req_read, req_ptr, req_count, wr_data} = 0;
        {flt, st, bitn} = {6'b10_1010, 8'hB5, 32'd0};
        repeat (20) @(posedge clock);
        #1 rst_n = 1;
        repeat (3) @(posedge clock);
        #1;
        t_write();
        t_read();
        t_reset();
        close_out();
    end
endmodule : tb_top
